// file: logic/tscs_pkg.sv
// Shared constants, types and helpers for the time snapshot and cable status block
package tscs_pkg;

   // Bus geometry
   localparam int unsigned ADR_W = 17;              // Byte address width
   localparam int unsigned DAT_W = 32;              // Data width
   localparam int unsigned SEL_W = DAT_W / 8;       // Byte lanes

   typedef logic [ADR_W-1:0] tscs_adr_t;

   // Register byte offsets, primary and mirrored
   localparam tscs_adr_t OFS_CABLE_CAP     = 17'h00210;
   localparam tscs_adr_t OFS_CABLE_SEC_CAP = 17'h00214;
   localparam tscs_adr_t OFS_IRIG_CAP      = 17'h00230;
   localparam tscs_adr_t OFS_IRIG_SEC_CAP  = 17'h00234;
   localparam tscs_adr_t OFS_MASTER_SEC    = 17'h00240;
   localparam tscs_adr_t OFS_ERR_CLEAR     = 17'h00400;
   localparam tscs_adr_t OFS_OUT_STATUS    = 17'h00410;
   localparam tscs_adr_t OFS_IN_STATUS     = 17'h00420;
   localparam tscs_adr_t OFS_IRQ_STATUS    = 17'h00500;
   localparam tscs_adr_t OFS_IRQ_MASK      = 17'h00504;
   localparam tscs_adr_t OFS_TICK_HI       = 17'h01000;
   localparam tscs_adr_t OFS_TICK_HI_M     = 17'h10000;
   localparam tscs_adr_t OFS_TICK_LO       = 17'h01008;
   localparam tscs_adr_t OFS_TICK_LO_M     = 17'h10008;
   localparam tscs_adr_t OFS_TICK_CTRL     = 17'h01010;
   localparam tscs_adr_t OFS_TICK_CTRL_M   = 17'h10010;
   localparam tscs_adr_t OFS_WALL_SEC      = 17'h01100;
   localparam tscs_adr_t OFS_WALL_SEC_M    = 17'h10100;
   localparam tscs_adr_t OFS_WALL_NS       = 17'h01108;
   localparam tscs_adr_t OFS_WALL_NS_M     = 17'h10108;
   localparam tscs_adr_t OFS_WALL_CTRL     = 17'h01110;
   localparam tscs_adr_t OFS_WALL_CTRL_M   = 17'h10110;

   // Clock rate and nanosecond stepping
   localparam int unsigned CLK_HZ     = 20000000;
   localparam int unsigned NS_PER_SEC = 1000000000;
   localparam int unsigned NS_STEP    = NS_PER_SEC / CLK_HZ;
   localparam int unsigned NS_W       = 30;
   localparam logic [NS_W-1:0] NS_INC   = NS_W'(NS_STEP);
   localparam logic [NS_W-1:0] NS_WRAP  = NS_W'(NS_PER_SEC - NS_STEP);
   localparam logic [NS_W-1:0] NS_LIMIT = NS_W'(NS_PER_SEC);

   // Snapshot layout: two seconds bits above the nanoseconds
   localparam int unsigned CAP_SEC_W = 2;

   // Link status layout
   localparam int unsigned FLAG_W   = 6;
   localparam int unsigned CNT_W    = 16;
   localparam int unsigned STAT_RSV = DAT_W - FLAG_W - CNT_W;
   localparam logic [CNT_W-1:0] CNT_MAX = 16'hFFFF;
   localparam int unsigned LNK_OUT  = 0;
   localparam int unsigned LNK_IN   = 1;
   localparam int unsigned LNK_N    = 2;

   // Control bits and reset values
   localparam int unsigned TCTL_RUN    = 0;
   localparam int unsigned WCTL_RUN    = 0;
   localparam int unsigned WCTL_MASTER = 1;
   localparam logic TCTL_RUN_RST    = 1'b1;
   localparam logic WCTL_RUN_RST    = 1'b1;
   localparam logic WCTL_MASTER_RST = 1'b0;

   // Interrupt event bits
   localparam int unsigned EV_CABLE   = 0;
   localparam int unsigned EV_IRIG    = 1;
   localparam int unsigned EV_MASTER  = 2;
   localparam int unsigned EV_OUT_ERR = 3;
   localparam int unsigned EV_IN_ERR  = 4;
   localparam int unsigned EV_W       = 5;

   // Bus slave states, one-hot
   typedef enum logic [1:0] {
      TSCS_BUS_IDLE = 2'b01,
      TSCS_BUS_ACK  = 2'b10
   } tscs_bus_t;

   // Byte-lane merge of write data into an old word
   function automatic logic [DAT_W-1:0] tscs_merge(input logic [DAT_W-1:0] old_w,
                                                   input logic [DAT_W-1:0] new_w,
                                                   input logic [SEL_W-1:0] sel);
      logic [DAT_W-1:0] res;
      res = old_w;
      for (int b = 0; b < SEL_W; b++) begin
         if (sel[b]) begin
            res[b*8 +: 8] = new_w[b*8 +: 8];
         end
      end
      return res;
   endfunction : tscs_merge

endpackage : tscs_pkg

// file: logic/tscs_link_status.sv
// Per-cable condition flags and saturating error counter
`timescale 1ns/1ps
`default_nettype none

module tscs_link_status (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          ce_i,
   input  wire logic [tscs_pkg::FLAG_W-1:0]   flags_i,
   input  wire logic                          err_i,
   input  wire logic                          clear_i,
   output logic      [tscs_pkg::DAT_W-1:0]    status_o
);

   logic [tscs_pkg::CNT_W-1:0] cnt_reg;   // Error count
   logic [tscs_pkg::CNT_W-1:0] cnt_next;  // Next error count

   // Clear first, then count, so an error in the clear cycle survives
   always_comb begin
      cnt_next = clear_i ? '0 : cnt_reg;                               // see [R6]
      if (err_i && (cnt_next != tscs_pkg::CNT_MAX)) begin
         cnt_next = cnt_next + 16'h0001;                               // see [R18]
      end
   end

   // Counter register
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cnt_reg <= '0;
      end else if (ce_i) begin
         cnt_reg <= cnt_next;
      end
   end

   // Status word; flags are live hardware conditions, sampled each cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         status_o <= '0;
      end else if (ce_i) begin
         status_o <= {{tscs_pkg::STAT_RSV{1'b0}}, flags_i, cnt_next};  // see [R10]
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_err_clear_zero: assert property (ce_i && clear_i && !err_i |=> cnt_reg == '0) // see [R6]
      else $error("error count not zero after clear");
   a_err_count_step: assert property (ce_i && err_i && !clear_i && // see [R18]
      cnt_reg != tscs_pkg::CNT_MAX |=> cnt_reg == $past(cnt_reg) + 16'h0001)
      else $error("error count did not step");
   a_err_count_sat: assert property (ce_i && err_i && !clear_i && // see [R18]
      cnt_reg == tscs_pkg::CNT_MAX |=> cnt_reg == tscs_pkg::CNT_MAX)
      else $error("error count wrapped");

endmodule : tscs_link_status

`default_nettype wire

// file: logic/tscs_time_snapshot.sv
// Top: timestamp captures, cable master seconds, cable status, tick and wall clocks
//
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`default_nettype none

// Overview of operation
// [R1] Cable arrival latches nanoseconds plus two seconds
// [R2] Cable arrival latches full seconds separately
// [R3] IRIG pulse latches nanoseconds plus two seconds
// [R4] IRIG pulse latches full seconds separately
// [R5] Master sends and holds seconds at rollover
// [R6] Error-clear write clears all cable errors; write-only
// [R7] Error-clear ignores written data value
// [R8] Outbound status: flags and error count, read-only
// [R9] Inbound status: same flags and count
// [R10] Six separate link condition flags
// [R11] Tick upper half at two mirrored offsets
// [R12] Tick lower half at two mirrored offsets
// [R13] Tick status/control at mirrored offsets
// [R14] Wall seconds at two mirrored offsets
// [R15] Wall nanoseconds at two mirrored offsets
// [R16] Wall clock status/control at mirrored offsets
// [R17] Seconds and nanoseconds captured same instant
// [R18] Error count saturates, clears on clear write
module tscs_time_snapshot (
   input  wire logic                          clk_i,
   input  wire logic                          rst_i,
   input  wire logic                          ce_i,
   input  wire logic                          wb_cyc_i,
   input  wire logic                          wb_stb_i,
   input  wire logic                          wb_we_i,
   input  wire logic [tscs_pkg::ADR_W-1:0]    wb_adr_i,
   input  wire logic [tscs_pkg::SEL_W-1:0]    wb_sel_i,
   input  wire logic [tscs_pkg::DAT_W-1:0]    wb_dat_i,
   output logic      [tscs_pkg::DAT_W-1:0]    wb_dat_o,
   output logic                               wb_ack_o,
   input  wire logic                          cable_time_rx_i,
   input  wire logic                          irig_pps_i,
   input  wire logic [tscs_pkg::FLAG_W-1:0]   out_link_flags_i,
   input  wire logic [tscs_pkg::FLAG_W-1:0]   in_link_flags_i,
   input  wire logic                          out_link_err_i,
   input  wire logic                          in_link_err_i,
   output logic      [tscs_pkg::DAT_W-1:0]    cable_tx_seconds_o,
   output logic                               cable_tx_valid_o,
   output logic                               irq_o
);

   // Bus slave
   tscs_pkg::tscs_bus_t         bus_state_reg;   // Slave state
   tscs_pkg::tscs_adr_t         adr;             // Word-aligned address
   logic                        req;             // New request this cycle
   logic                        wr_go;           // Write commit at the ack edge
   logic [tscs_pkg::DAT_W-1:0]  rd_data;         // Read mux

   // Clocks
   logic [63:0]                 tick_reg;        // Tick count, steps each cycle while enabled
   logic                        tick_run_reg;    // Tick counter enable
   logic [31:0]                 wall_sec_reg;    // Wall clock seconds
   logic [tscs_pkg::NS_W-1:0]   wall_ns_reg;     // Wall clock nanoseconds
   logic                        wall_run_reg;    // Wall clock enable
   logic                        master_reg;      // Act as cable master
   logic                        sec_roll;        // Seconds boundary this cycle
   logic [31:0]                 sec_next;        // Next seconds value
   logic [tscs_pkg::NS_W-1:0]   ns_next;         // Next nanoseconds value

   // Captures
   logic                        cable_rx_d_reg;  // Delayed cable strobe
   logic                        irig_d_reg;      // Delayed pulse input
   logic                        cable_ev;        // Cable time arrival
   logic                        irig_ev;         // IRIG pulse edge
   logic                        master_ev;       // Master seconds sent
   logic [31:0]                 cable_cap_reg;   // Cable ns snapshot
   logic [31:0]                 cable_sec_reg;   // Cable seconds snapshot
   logic [31:0]                 irig_cap_reg;    // IRIG ns snapshot
   logic [31:0]                 irig_sec_reg;    // IRIG seconds snapshot
   logic [31:0]                 master_sec_reg;  // Last seconds sent
   logic [31:0]                 snap_word;       // Seconds bits over nanoseconds

   // Links and interrupts
   logic                        err_clear;       // Error-clear strobe
   logic [tscs_pkg::FLAG_W-1:0] lnk_flags [tscs_pkg::LNK_N];
   logic                        lnk_err   [tscs_pkg::LNK_N];
   logic [tscs_pkg::DAT_W-1:0]  lnk_status [tscs_pkg::LNK_N];
   logic [tscs_pkg::EV_W-1:0]   ev_vec;          // Event pulses
   logic [tscs_pkg::EV_W-1:0]   irq_stat_reg;    // Sticky events
   logic [tscs_pkg::EV_W-1:0]   irq_mask_reg;    // Interrupt enables
   logic [tscs_pkg::EV_W-1:0]   irq_clr;         // Write-one-to-clear bits

   // Address decode ignores the byte offset within a word
   assign adr   = {wb_adr_i[tscs_pkg::ADR_W-1:2], 2'b00};
   assign req   = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign wr_go = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

   // One wait state: ack a cycle after the strobe, drop it a cycle later
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         bus_state_reg <= tscs_pkg::TSCS_BUS_IDLE;
         wb_ack_o      <= 1'b0;
      end else if (ce_i) begin
         case (bus_state_reg)
            tscs_pkg::TSCS_BUS_IDLE: begin
               wb_ack_o <= req;
               if (req) begin
                  bus_state_reg <= tscs_pkg::TSCS_BUS_ACK;
               end
            end
            tscs_pkg::TSCS_BUS_ACK: begin
               wb_ack_o      <= 1'b0;
               bus_state_reg <= tscs_pkg::TSCS_BUS_IDLE;
            end
            default: begin
               wb_ack_o      <= 1'b0;
               bus_state_reg <= tscs_pkg::TSCS_BUS_IDLE;
            end
         endcase
      end
   end

   // Read mux; unmapped and write-only words read as zero
   always_comb begin
      rd_data = '0;
      case (adr)
         tscs_pkg::OFS_CABLE_CAP:     rd_data = cable_cap_reg;
         tscs_pkg::OFS_CABLE_SEC_CAP: rd_data = cable_sec_reg;
         tscs_pkg::OFS_IRIG_CAP:      rd_data = irig_cap_reg;
         tscs_pkg::OFS_IRIG_SEC_CAP:  rd_data = irig_sec_reg;
         tscs_pkg::OFS_MASTER_SEC:    rd_data = master_sec_reg;                     // see [R5]
         tscs_pkg::OFS_OUT_STATUS:    rd_data = lnk_status[tscs_pkg::LNK_OUT];      // see [R8]
         tscs_pkg::OFS_IN_STATUS:     rd_data = lnk_status[tscs_pkg::LNK_IN];       // see [R9]
         tscs_pkg::OFS_IRQ_STATUS:    rd_data[tscs_pkg::EV_W-1:0] = irq_stat_reg;
         tscs_pkg::OFS_IRQ_MASK:      rd_data[tscs_pkg::EV_W-1:0] = irq_mask_reg;
         tscs_pkg::OFS_TICK_HI,
         tscs_pkg::OFS_TICK_HI_M:     rd_data = tick_reg[63:32];                    // see [R11]
         tscs_pkg::OFS_TICK_LO,
         tscs_pkg::OFS_TICK_LO_M:     rd_data = tick_reg[31:0];                     // see [R12]
         tscs_pkg::OFS_TICK_CTRL,
         tscs_pkg::OFS_TICK_CTRL_M:   rd_data[tscs_pkg::TCTL_RUN] = tick_run_reg;   // see [R13]
         tscs_pkg::OFS_WALL_SEC,
         tscs_pkg::OFS_WALL_SEC_M:    rd_data = wall_sec_reg;                       // see [R14]
         tscs_pkg::OFS_WALL_NS,
         tscs_pkg::OFS_WALL_NS_M:     rd_data[tscs_pkg::NS_W-1:0] = wall_ns_reg;    // see [R15]
         tscs_pkg::OFS_WALL_CTRL,
         tscs_pkg::OFS_WALL_CTRL_M: begin                                           // see [R16]
            rd_data[tscs_pkg::WCTL_RUN]    = wall_run_reg;
            rd_data[tscs_pkg::WCTL_MASTER] = master_reg;
         end
         default:                     rd_data = '0;
      endcase
   end

   // Read data is latched with the ack and held while it stands
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (ce_i && req) begin
         wb_dat_o <= rd_data;
      end
   end

   // Tick counter; a half written by software overrides the increment
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         tick_reg     <= '0;
         tick_run_reg <= tscs_pkg::TCTL_RUN_RST;
      end else if (ce_i) begin
         if (tick_run_reg) begin
            tick_reg <= tick_reg + 64'h1;
         end
         if (wr_go && (adr == tscs_pkg::OFS_TICK_HI || adr == tscs_pkg::OFS_TICK_HI_M)) begin
            tick_reg[63:32] <= tscs_pkg::tscs_merge(tick_reg[63:32], wb_dat_i, wb_sel_i);
         end
         if (wr_go && (adr == tscs_pkg::OFS_TICK_LO || adr == tscs_pkg::OFS_TICK_LO_M)) begin
            tick_reg[31:0] <= tscs_pkg::tscs_merge(tick_reg[31:0], wb_dat_i, wb_sel_i);
         end
         if (wr_go && wb_sel_i[0] &&
             (adr == tscs_pkg::OFS_TICK_CTRL || adr == tscs_pkg::OFS_TICK_CTRL_M)) begin
            tick_run_reg <= wb_dat_i[tscs_pkg::TCTL_RUN];
         end
      end
   end

   // Wall clock next state; a software write wins over the step
   assign sec_roll = wall_run_reg && (wall_ns_reg >= tscs_pkg::NS_WRAP);
   always_comb begin
      ns_next  = wall_ns_reg;
      sec_next = wall_sec_reg;
      if (sec_roll) begin
         ns_next  = '0;
         sec_next = wall_sec_reg + 32'h1;
      end else if (wall_run_reg) begin
         ns_next = wall_ns_reg + tscs_pkg::NS_INC;
      end
      if (wr_go && (adr == tscs_pkg::OFS_WALL_SEC || adr == tscs_pkg::OFS_WALL_SEC_M)) begin
         sec_next = tscs_pkg::tscs_merge(wall_sec_reg, wb_dat_i, wb_sel_i);
      end
      if (wr_go && (adr == tscs_pkg::OFS_WALL_NS || adr == tscs_pkg::OFS_WALL_NS_M)) begin
         // Out-of-range values are not stored; the clock never leaves one second
         if (wb_dat_i[tscs_pkg::NS_W-1:0] < tscs_pkg::NS_LIMIT) begin
            ns_next = wb_dat_i[tscs_pkg::NS_W-1:0];
         end
      end
   end

   // Wall clock registers and control
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wall_sec_reg <= '0;
         wall_ns_reg  <= '0;
         wall_run_reg <= tscs_pkg::WCTL_RUN_RST;
         master_reg   <= tscs_pkg::WCTL_MASTER_RST;
      end else if (ce_i) begin
         wall_sec_reg <= sec_next;
         wall_ns_reg  <= ns_next;
         if (wr_go && wb_sel_i[0] &&
             (adr == tscs_pkg::OFS_WALL_CTRL || adr == tscs_pkg::OFS_WALL_CTRL_M)) begin
            wall_run_reg <= wb_dat_i[tscs_pkg::WCTL_RUN];
            master_reg   <= wb_dat_i[tscs_pkg::WCTL_MASTER];
         end
      end
   end

   // Cable master: send the new seconds at each boundary and keep it
   assign master_ev = sec_roll && master_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         master_sec_reg     <= '0;
         cable_tx_seconds_o <= '0;
         cable_tx_valid_o   <= 1'b0;
      end else if (ce_i) begin
         cable_tx_valid_o <= master_ev;                                 // see [R5]
         if (master_ev) begin
            master_sec_reg     <= sec_next;                             // see [R5]
            cable_tx_seconds_o <= sec_next;
         end
      end
   end

   // Rising-edge detect; inputs are already synchronous
   assign cable_ev = cable_time_rx_i && !cable_rx_d_reg;
   assign irig_ev  = irig_pps_i && !irig_d_reg;
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cable_rx_d_reg <= 1'b0;
         irig_d_reg     <= 1'b0;
      end else if (ce_i) begin
         cable_rx_d_reg <= cable_time_rx_i;
         irig_d_reg     <= irig_pps_i;
      end
   end

   // Both halves of a capture word come from one cycle, so they never tear
   assign snap_word = {wall_sec_reg[tscs_pkg::CAP_SEC_W-1:0], wall_ns_reg}; // see [R17]

   // Snapshots take the clock as it stands in the event cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         cable_cap_reg <= '0;
         cable_sec_reg <= '0;
         irig_cap_reg  <= '0;
         irig_sec_reg  <= '0;
      end else if (ce_i) begin
         if (cable_ev) begin
            cable_cap_reg <= snap_word;      // see [R1] [R17]
            cable_sec_reg <= wall_sec_reg;   // see [R2] [R17]
         end
         if (irig_ev) begin
            irig_cap_reg <= snap_word;       // see [R3] [R17]
            irig_sec_reg <= wall_sec_reg;    // see [R4] [R17]
         end
      end
   end

   // Any write to the clear word clears both links, data unused
   assign err_clear = wr_go && (adr == tscs_pkg::OFS_ERR_CLEAR);        // see [R6] [R7]

   assign lnk_flags[tscs_pkg::LNK_OUT] = out_link_flags_i;
   assign lnk_flags[tscs_pkg::LNK_IN]  = in_link_flags_i;
   assign lnk_err[tscs_pkg::LNK_OUT]   = out_link_err_i;
   assign lnk_err[tscs_pkg::LNK_IN]    = in_link_err_i;

   // One status block per cable
   for (genvar g = 0; g < tscs_pkg::LNK_N; g++) begin : g_link
      tscs_link_status u_link (
         .clk_i    (clk_i),
         .rst_i    (rst_i),
         .ce_i     (ce_i),
         .flags_i  (lnk_flags[g]),
         .err_i    (lnk_err[g]),
         .clear_i  (err_clear),
         .status_o (lnk_status[g])
      );
   end

   // Event vector feeding the sticky status
   always_comb begin
      ev_vec                       = '0;
      ev_vec[tscs_pkg::EV_CABLE]   = cable_ev;
      ev_vec[tscs_pkg::EV_IRIG]    = irig_ev;
      ev_vec[tscs_pkg::EV_MASTER]  = master_ev;
      ev_vec[tscs_pkg::EV_OUT_ERR] = out_link_err_i;
      ev_vec[tscs_pkg::EV_IN_ERR]  = in_link_err_i;
   end

   assign irq_clr = (wr_go && wb_sel_i[0] && adr == tscs_pkg::OFS_IRQ_STATUS) ?
                    wb_dat_i[tscs_pkg::EV_W-1:0] : '0;

   // Sticky status: a new event beats a clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         irq_stat_reg <= '0;
         irq_mask_reg <= '0;
         irq_o        <= 1'b0;
      end else if (ce_i) begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | ev_vec;
         if (wr_go && wb_sel_i[0] && adr == tscs_pkg::OFS_IRQ_MASK) begin
            irq_mask_reg <= wb_dat_i[tscs_pkg::EV_W-1:0];
         end
         // One cycle behind the status, traded for a registered output
         irq_o <= |(irq_stat_reg & irq_mask_reg);
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   a_cable_ns_cap: assert property (ce_i && cable_ev |=> // see [R1]
      cable_cap_reg == {$past(wall_sec_reg[1:0]), $past(wall_ns_reg)})
      else $error("cable snapshot does not match clock");
   a_cable_sec_cap: assert property (ce_i && cable_ev |=> // see [R2]
      cable_sec_reg == $past(wall_sec_reg))
      else $error("cable seconds snapshot wrong");
   a_irig_ns_cap: assert property (ce_i && irig_ev |=> // see [R3]
      irig_cap_reg == {$past(wall_sec_reg[1:0]), $past(wall_ns_reg)})
      else $error("irig snapshot does not match clock");
   a_irig_sec_cap: assert property (ce_i && irig_ev |=> // see [R4]
      irig_sec_reg == $past(wall_sec_reg))
      else $error("irig seconds snapshot wrong");
   a_capture_pair_coherent: assert property (ce_i && cable_ev |=> // see [R17]
      cable_cap_reg[31:30] == cable_sec_reg[1:0])
      else $error("cable snapshot pair inconsistent");
   // A seconds write in the rollover cycle is what goes out, so compare to the clock
   a_master_send: assert property (ce_i && master_ev |=> cable_tx_valid_o && // see [R5]
      cable_tx_seconds_o == master_sec_reg && master_sec_reg == wall_sec_reg)
      else $error("master seconds not sent at rollover");
   a_master_quiet: assert property (ce_i && !master_reg |=> !cable_tx_valid_o) // see [R5]
      else $error("non-master sent seconds");
   a_ns_in_range: assert property (wall_ns_reg < tscs_pkg::NS_LIMIT) // see [R15]
      else $error("nanoseconds out of range");
   a_ack_single: assert property (ce_i && wb_ack_o |=> !wb_ack_o)
      else $error("ack stood two cycles");
   a_irq_gated: assert property (ce_i |=> irq_o == $past(|(irq_stat_reg & irq_mask_reg)))
      else $error("interrupt output does not follow masked status");

   c_cable_capture: cover property (ce_i && cable_ev);
   c_irig_capture:  cover property (ce_i && irig_ev);
   c_master_send:   cover property (ce_i && master_ev ##1 cable_tx_valid_o);
   c_error_clear:   cover property (ce_i && err_clear);
   c_irq_raise:     cover property (!irq_o ##1 irq_o);

endmodule : tscs_time_snapshot

`default_nettype wire

// file: verification/tscs_cable_peer.sv
// Far-side timing board that sends master time down the cable
`timescale 1ns/1ps
`default_nettype none
module tscs_cable_peer (
   input  wire logic send_i,
   input  wire logic clk_i,
   output var  logic time_rx_o = 1'b0
);
   // One-cycle arrival strobe; forced low between sends so no edge is lost
   always_ff @(posedge clk_i) begin
      time_rx_o <= send_i & ~time_rx_o;
   end
endmodule : tscs_cable_peer
`default_nettype wire

// file: verification/testbench.sv
// Self-checking bench for the time snapshot and cable status block
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, snd = 0, pps = 0;
   logic        rx, ack, txv, irq, ie = 0, oe = 0;
   logic [16:0] adr = 17'h0;
   logic [31:0] dat = 32'h0, q, dout, txs;
   logic [5:0]  inf = 6'h2A, outf = 6'h15;
   int          fails = 0, checked = 0;
   // Free-running 50 ns clock
   always #25 clk_i = ~clk_i;
   tscs_cable_peer u_peer (.clk_i(clk_i), .send_i(snd), .time_rx_o(rx));
   tscs_time_snapshot u_dut (.clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc),
      .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
      .wb_dat_o(dout), .wb_ack_o(ack), .cable_time_rx_i(rx), .irig_pps_i(pps),
      .out_link_flags_i(outf), .in_link_flags_i(inf), .out_link_err_i(oe),
      .in_link_err_i(ie), .cable_tx_seconds_o(txs), .cable_tx_valid_o(txv), .irq_o(irq));
   task automatic final_report;
      $display("fails=%0d checked=%0d", fails, checked);
      if (fails == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : final_report
   task automatic chk(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e) begin
         fails++;
         $display("CHECK FAILED %0t got %h want %h", $time, g, e);
      end
   endtask : chk
   task automatic tick(input int n);
      repeat (n) @(posedge clk_i);
   endtask : tick
   // Classic single cycle; bounded wait for the slave's ack
   task automatic bus(input logic w, input logic [16:0] a, input logic [31:0] d);
      int n;
      n = 0;
      @(posedge clk_i);
      {cyc, stb, we, adr, dat} <= {1'b1, 1'b1, w, a, d};
      do begin
         @(posedge clk_i);
         n++;
      end while (ack !== 1'b1 && n < 20);
      q = dout;
      {cyc, stb} <= 2'h0;
      if (n >= 20) begin
         fails++;
         $display("CHECK FAILED %0t no bus ack", $time);
         final_report();
      end
   endtask : bus
   task automatic wr(input logic [16:0] a, input logic [31:0] d);
      bus(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [16:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0);
      chk(q, e);
   endtask : rd
   initial begin
      tick(16);
      rst_i <= 1'b0;
      // Freeze wall clock so snapshots are exact
      wr(17'h01110, 32'h0);
      wr(17'h10100, 32'h7);
      wr(17'h10108, 32'h64);
      rd(17'h10110, 32'h0);
      rd(17'h01100, 32'h7);
      rd(17'h01108, 32'h64);
      @(posedge clk_i);
      snd <= 1'b1;
      @(posedge clk_i);
      {snd, pps} <= 2'h1;
      tick(2);
      pps <= 1'b0;
      rd(17'h00210, 32'hC0000064);
      rd(17'h00214, 32'h7);
      rd(17'h00230, 32'hC0000064);
      rd(17'h00234, 32'h7);
      $display("capture test done");
      wr(17'h10010, 32'h0);
      wr(17'h01000, 32'h12345678);
      rd(17'h10000, 32'h12345678);
      wr(17'h10008, 32'hCAFE0001);
      rd(17'h01008, 32'hCAFE0001);
      rd(17'h01010, 32'h0);
      $display("mirror test done");
      // Master mode, 100 ns short of a seconds boundary
      wr(17'h01110, 32'h3);
      wr(17'h01100, 32'h9);
      wr(17'h01108, 32'h3B9AC99C);
      for (int i = 0; i < 20 && txv !== 1'b1; i++) @(posedge clk_i);
      // A send that never comes ends the run as a mismatch
      if (txv !== 1'b1) begin
         fails++;
         $display("CHECK FAILED %0t no master send", $time);
         final_report();
      end
      chk(txs, 32'hA);
      rd(17'h00240, 32'hA);
      $display("master test done");
      // Three inbound errors; outbound held long enough to saturate
      ie <= 1'b1;
      tick(3);
      {ie, oe} <= 2'h1;
      tick(65540);
      oe <= 1'b0;
      rd(17'h00420, 32'h002A0003);
      rd(17'h00410, 32'h0015FFFF);
      wr(17'h00400, 32'h000000A5);
      rd(17'h00420, 32'h002A0000);
      rd(17'h00410, 32'h00150000);
      rd(17'h00400, 32'h0);
      $display("link test done");
      // Pending events stay quiet until unmasked
      chk({31'h0, irq}, 32'h0);
      wr(17'h00504, 32'h10);
      ie <= 1'b1;
      @(posedge clk_i);
      ie <= 1'b0;
      tick(3);
      chk({31'h0, irq}, 32'h1);
      wr(17'h00500, 32'h1F);
      tick(2);
      chk({31'h0, irq}, 32'h0);
      $display("irq test done");
      final_report();
   end
endmodule : testbench
`default_nettype wire
